// ### dv/sht_card_model.sv
// behavioural card: gated bus clock, tuning pattern result, dat1 interrupt
`timescale 1ns/1ps
module sht_card_model
    import sht_pkg::*;
(
    input  wire logic       clk_on,     // host card clock gate
    input  wire logic [4:0] ok_after,   // edges until pattern matches, 31 never
    input  wire logic       irq_req,    // card wants an interrupt
    input  wire logic [4:0] pat,        // changing line pattern
    output logic            card_bus_clock,
    output logic            cmd_line,
    output logic [3:0]      dat_line,
    output logic            pattern_ok
);
    int n_edges;    // rises since the clock was last enabled

    // clock stands low whenever the host gates it off
    initial begin
        card_bus_clock = 1'b0;
        n_edges = 0;
        #7;
        forever begin
            #100;
            if (clk_on) begin
                card_bus_clock = ~card_bus_clock;
                if (card_bus_clock)
                    n_edges = n_edges + 1;
            end else begin
                card_bus_clock = 1'b0;
                n_edges = 0;
            end
        end
    end

    // dat1 pulled high, card pulls it low to interrupt
    assign dat_line   = {pat[3:2], ~irq_req, pat[0]};
    assign cmd_line   = pat[4];
    assign pattern_ok = (ok_after != 5'h1f) && (n_edges >= int'(ok_after));
endmodule

// ### dv/sht_tuning_ctrl_chk.sv
// port level checker for the tuning and async card interrupt block
`timescale 1ns/1ps
`include "sht_consts.svh"
module sht_tuning_ctrl_chk
    import sht_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        card_bus_clock,
    input wire logic        cmd_line,
    input wire logic [3:0]  dat_line,
    input wire logic        pattern_ok,
    input wire logic        card_clock_enable,
    input wire logic        cmd_sample,
    input wire logic [3:0]  dat_sample,
    input wire logic        sample_valid,
    input wire logic        irq
);
    // ****************************************
    // one clock domain, reset disables all
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // every setup cycle is answered in the next cycle
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("setup cycle not answered");
    // answer stands one cycle only
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    // capability word reads the strap
    caps_read_a: assert property (pready && !pwrite && paddr == `SHT_OFF_CAPS
        |-> prdata == 32'h1)
        else $error("capability bit wrong");
    // card clock gate only moves on a control write
    clk_gate_cause_a: assert property ($changed(card_clock_enable)
        |-> $past(psel && penable && pwrite && paddr == `SHT_OFF_CTRL))
        else $error("card clock enable moved without write");
    sample_pulse_a: assert property (sample_valid |=> !sample_valid)
        else $error("sample valid longer than one cycle");
    // each card clock rise yields a sample soon after sync
    sample_follow_a: assert property ($rose(card_bus_clock) |-> ##[1:7] sample_valid)
        else $error("no sample after card clock edge");
    // irq only drops after a bus access
    irq_drop_a: assert property ($fell(irq)
        |-> $past(psel, 1) || $past(psel, 2) || $past(psel, 3))
        else $error("irq dropped without access");
endmodule

bind sht_tuning_ctrl sht_tuning_ctrl_chk sht_tuning_ctrl_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .card_bus_clock(card_bus_clock), .cmd_line(cmd_line), .dat_line(dat_line),
    .pattern_ok(pattern_ok), .card_clock_enable(card_clock_enable),
    .cmd_sample(cmd_sample), .dat_sample(dat_sample), .sample_valid(sample_valid), .irq(irq));

// ### dv/sht_tuning_ctrl_test.sv
// self-checking testbench for the tuning and async card interrupt block
`timescale 1ns/1ps
`include "sht_consts.svh"
module sht_tuning_ctrl_test
    import sht_pkg::*;
;
    typedef struct packed { logic [31:0] x; logic [31:0] m; logic e; } sht_note_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, irq_req;
    logic        card_bus_clock, cmd_line, pattern_ok, card_clock_enable, cmd_sample;
    logic        sample_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;    // rv holds the last read word
    logic [3:0]  dat_line, dat_sample;
    logic [4:0]  ok_after, pat;
    logic [7:0]  lf;                    // pattern generator state
    sht_note_s   q[$];                  // expected answers, oldest first
    sht_note_s   nt;
    int          n_errors, tests_run, cyc;
    logic [4:0]  sq[$];                 // lines noted at each card clock rise
    logic [4:0]  ex5;                   // oldest noted line value
    logic        ck_prev, fix_chk;      // last card clock level, fixed path check on

    sht_tuning_ctrl sht_tuning_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .card_bus_clock(card_bus_clock),
        .cmd_line(cmd_line), .dat_line(dat_line), .pattern_ok(pattern_ok),
        .card_clock_enable(card_clock_enable), .cmd_sample(cmd_sample),
        .dat_sample(dat_sample), .sample_valid(sample_valid), .irq(irq));
    sht_card_model sht_card_model_inst (.clk_on(card_clock_enable), .ok_after(ok_after),
        .irq_req(irq_req), .pat(pat), .card_bus_clock(card_bus_clock),
        .cmd_line(cmd_line), .dat_line(dat_line), .pattern_ok(pattern_ok));

    // ****************************************
    // clock, line pattern, timeout, monitor
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    always @(posedge pclk) begin
        lf  <= lfsr(lf);
        pat <= lf[4:0];
        cyc <= cyc + 1;
        if (cyc == 20000) begin // hang guard
            n_errors = n_errors + 1;
            final_report();
        end
    end
    // oldest note checked whenever an answer is taken
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            nt = q.pop_front();
            cmp32("prdata", nt.x, prdata & nt.m);
            cmpb("pslverr", nt.e, pslverr);
        end
    end
    // fixed path: every seen card clock rise comes back as the next sample
    always @(posedge pclk) begin
        if (!presetn) begin
            sq.delete();
        end else begin
            if (sample_valid === 1'b1 && sq.size() > 0) begin
                ex5 = sq.pop_front();
                if (fix_chk)
                    cmp32("line sample", {27'h0, ex5}, {27'h0, cmd_sample, dat_sample});
            end
            // lines as the design's first sync flops take them
            if (card_bus_clock === 1'b1 && ck_prev === 1'b0)
                sq.push_back({cmd_line, dat_line});
        end
        ck_prev <= card_bus_clock;
    end

    task automatic cmp32(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== ex) begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic cmpb(input string nm, input logic ex, input logic got);
        cmp32(nm, {31'h0, ex}, {31'h0, got});
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] x, input logic e);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        q.push_back('{x, m, e});
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0, m, x, 1'b0);
    endtask
    // poll until the start bit has cleared itself
    task automatic tune_wait;
        repeat (300) begin
            rd(`SHT_OFF_CTRL, 32'h0, 32'h0);
            if (rv[0] === 1'b0) break;
        end
    endtask
    task automatic waitirq(input logic e);
        repeat (10) @(posedge pclk);
        cmpb("irq", e, irq);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; irq_req = 1'b0; ok_after = 5'h02; lf = 8'h47; pat = 5'h00;
        n_errors = 0; tests_run = 0; cyc = 0; fix_chk = 1'b0; ck_prev = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SHT_OFF_CTRL, 32'h1f, 32'h0);
        rd(`SHT_OFF_CAPS, 32'h1, 32'h1);
        apb(1'b0, 12'h020, 32'h0, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b1, 12'h024, 32'h5, 32'h0, 32'h0, 1'b1);
        wr(`SHT_OFF_MASK, 32'h7);
        $display("test reset and map done");
        wr(`SHT_OFF_CTRL, 32'h19);
        tune_wait();
        cmpb("card clock enable", 1'b1, card_clock_enable);
        rd(`SHT_OFF_CTRL, 32'h3, 32'h2);
        waitirq(1'b1);
        rd(`SHT_OFF_STATUS, 32'h3, 32'h1);
        waitirq(1'b0);
        wr(`SHT_OFF_CTRL, 32'h18);
        rd(`SHT_OFF_CTRL, 32'h3, 32'h0);
        rd(`SHT_OFF_STATE, 32'hf01, 32'h0);
        // choice is zero from here until the quick retune passes
        fix_chk = 1'b1;
        wr(`SHT_OFF_CTRL, 32'h1a);
        rd(`SHT_OFF_CTRL, 32'h3, 32'h0);
        $display("test tuning pass done");
        ok_after <= 5'h1f;
        wr(`SHT_OFF_CTRL, 32'h19);
        tune_wait();
        rd(`SHT_OFF_CTRL, 32'h3, 32'h0);
        rd(`SHT_OFF_STATUS, 32'h3, 32'h2);
        fix_chk = 1'b0;
        ok_after <= 5'h01;
        wr(`SHT_OFF_CTRL, 32'h1b);
        tune_wait();
        rd(`SHT_OFF_STATUS, 32'h3, 32'h1);
        $display("test tuning fail done");
        // no match on the lines, so edges still in the sync chain cannot pass
        ok_after <= 5'h1f;
        wr(`SHT_OFF_CTRL, 32'h0b);
        rd(`SHT_OFF_CTRL, 32'h3, 32'h1);
        cmpb("card clock enable", 1'b0, card_clock_enable);
        rd(`SHT_OFF_STATE, 32'h1, 32'h1);
        wr(`SHT_OFF_CTRL, 32'h08);
        rd(`SHT_OFF_CTRL, 32'h3, 32'h0);
        rd(`SHT_OFF_STATUS, 32'h3, 32'h2);
        $display("test abort done");
        wr(`SHT_OFF_CTRL, 32'h0c);
        irq_req <= 1'b1;
        waitirq(1'b1);
        irq_req <= 1'b0;
        repeat (5) @(posedge pclk);
        rd(`SHT_OFF_STATUS, 32'h4, 32'h4);
        waitirq(1'b0);
        wr(`SHT_OFF_MASK, 32'h0);
        irq_req <= 1'b1;
        waitirq(1'b0);
        irq_req <= 1'b0;
        repeat (5) @(posedge pclk);
        rd(`SHT_OFF_STATUS, 32'h4, 32'h4);
        wr(`SHT_OFF_MASK, 32'h7);
        wr(`SHT_OFF_CTRL, 32'h04);
        irq_req <= 1'b1;
        waitirq(1'b0);
        rd(`SHT_OFF_STATUS, 32'h4, 32'h0);
        irq_req <= 1'b0;
        $display("test card interrupt done");
        wr(`SHT_OFF_CTRL, 32'h05);
        presetn <= 1'b0;    // reset in mid-run with tuning busy
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SHT_OFF_CTRL, 32'h1f, 32'h0);
        rd(`SHT_OFF_STATE, 32'h1, 32'h0);
        $display("test reset in mid-run done");
        final_report();
    end
endmodule

// ### hdl/sht_tuner.sv
// tuning engine: walks the sampling taps until the pattern check passes
`timescale 1ns/1ps
module sht_tuner
    import sht_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  start_p,
    input  wire logic                  abort_p,
    input  wire logic                  circ_rst_p,
    input  wire logic                  link_edge,
    input  wire logic                  pattern_ok,
    output logic                       busy,
    output logic                       done,
    output logic                       pass,
    output logic [`SHT_TAP_W-1:0]      tap
);
    sht_tune_s s_q;   // registered state
    sht_tune_s s_d;   // next state

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        // circuit reset drops the learned tap, so the next search is long
        if (circ_rst_p) begin
            s_d.tap  = `SHT_RST_TAP;
            s_d.pass = 1'b0;
        end
        unique case (s_q.st)
            SHT_IDLE: begin
                if (start_p) begin
                    // retune starts at the kept tap: quick when still good
                    s_d.st    = SHT_SEEK;
                    s_d.tries = '0;
                    s_d.pass  = 1'b0;
                end
            end
            SHT_SEEK: begin
                if (abort_p) begin
                    s_d.st   = SHT_IDLE;   // abort reports failure
                    s_d.pass = 1'b0;
                    s_d.done = 1'b1;
                end else if (link_edge) begin
                    if (pattern_ok) begin
                        s_d.st   = SHT_IDLE;
                        s_d.pass = 1'b1;
                        s_d.done = 1'b1;
                    end else if (s_q.tries == `SHT_TAP_LAST) begin
                        s_d.st   = SHT_IDLE;   // every tap tried
                        s_d.pass = 1'b0;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.tries = s_q.tries + 4'h1;
                        s_d.tap   = s_d.tap + 4'h1;
                    end
                end
            end
        endcase
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{st: SHT_IDLE, tap: `SHT_RST_TAP, tries: '0, pass: 1'b0, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.st == SHT_SEEK);
    assign done = s_q.done;
    assign pass = s_q.pass;
    assign tap  = s_q.tap;
endmodule

// ### hdl/sht_tuning_ctrl.sv
// card sampling tuning and asynchronous card interrupt control with apb registers
`timescale 1ns/1ps

module sht_tuning_ctrl
    import sht_pkg::*;
#(
    parameter logic ASYNC_CAP = 1'b1    // async interrupt capability strap
)
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic [31:0]                 prdata,
    input  wire logic                   card_bus_clock,
    input  wire logic                   cmd_line,
    input  wire logic [3:0]             dat_line,
    input  wire logic                   pattern_ok,
    output logic                        card_clock_enable,
    output logic                        cmd_sample,
    output logic [3:0]                  dat_sample,
    output logic                        sample_valid,
    output logic                        irq
);
    sht_main_s s_q;                     // registered state
    sht_main_s s_d;                     // next state

    logic                  t_busy;      // tuning running
    logic                  t_done;      // tuning finished, one cycle
    logic                  t_pass;      // last tuning passed
    logic [`SHT_TAP_W-1:0] t_tap;       // tuned sampling tap
    logic                  link_edge;   // card clock rising edge seen
    logic                  acc;         // apb access completes now
    logic                  wr_ctrl;     // write to control register
    logic                  start_p;     // start request
    logic                  abort_p;     // abort request
    logic                  circ_rst_p;  // tuner reset request

    // ************************************************
    // address decode helpers
    // ************************************************
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `SHT_OFF_CTRL) || (a == `SHT_OFF_STATUS) ||
                    (a == `SHT_OFF_MASK) || (a == `SHT_OFF_CAPS) ||
                    (a == `SHT_OFF_STATE);
    endfunction

    // read mux, used at setup to prepare the answer
    function automatic logic [31:0] rd_mux(input logic [11:0] a, input sht_main_s s,
                                           input logic busy, input logic [`SHT_TAP_W-1:0] tp);
        rd_mux = 32'h0000_0000;
        unique case (a)
            `SHT_OFF_CTRL: begin
                rd_mux[`SHT_CTRL_START]  = s.start;
                rd_mux[`SHT_CTRL_CHOICE] = s.choice;
                rd_mux[`SHT_CTRL_ASYNC]  = s.async_en;
                rd_mux[`SHT_CTRL_BUS4]   = s.bus4;
                rd_mux[`SHT_CTRL_CLKEN]  = s.clk_en;
            end
            `SHT_OFF_STATUS: rd_mux[`SHT_ST_W-1:0] = s.stat;
            `SHT_OFF_MASK:   rd_mux[`SHT_ST_W-1:0] = s.mask;
            `SHT_OFF_CAPS:   rd_mux[`SHT_CAP_ASYNC] = ASYNC_CAP;
            `SHT_OFF_STATE: begin
                rd_mux[`SHT_STATE_BUSY] = busy;
                rd_mux[`SHT_STATE_TAP +: `SHT_TAP_W] = tp;
            end
            default: rd_mux = 32'h0000_0000;   // unmapped reads zero
        endcase
    endfunction

    // ************************************************
    // request decode
    // ************************************************
    // the card clock is only sampled: edges come from the second sync flop
    assign link_edge  = s_q.clk_sy[1] & ~s_q.clk_prev;
    assign acc        = psel & penable & s_q.pready;
    assign wr_ctrl    = acc & pwrite & (paddr == `SHT_OFF_CTRL);
    assign start_p    = wr_ctrl & pwdata[`SHT_CTRL_START] & ~t_busy;
    assign abort_p    = wr_ctrl & ~pwdata[`SHT_CTRL_START] & t_busy;
    assign circ_rst_p = wr_ctrl & ~pwdata[`SHT_CTRL_CHOICE];

    // ************************************************
    // tuning engine
    // ************************************************
    sht_tuner u_tuner (
        .pclk       (pclk),
        .presetn    (presetn),
        .start_p    (start_p),
        .abort_p    (abort_p),
        .circ_rst_p (circ_rst_p),
        .link_edge  (link_edge),
        .pattern_ok (s_q.ok_sy[1]),
        .busy       (t_busy),
        .done       (t_done),
        .pass       (t_pass),
        .tap        (t_tap)
    );

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic [`SHT_ST_W-1:0]   ev;        // events this cycle
        logic [`SHT_LINE_W-1:0] ln;        // synced lines, cmd in bit 4
        logic                   dat1_low;  // card pulls dat1 low
        ev       = '0;
        ln       = s_q.ln_s2;
        dat1_low = ~ln[1];
        s_d      = s_q;

        // two flop synchronisers for every pin input
        s_d.clk_sy   = {s_q.clk_sy[0], card_bus_clock};
        s_d.clk_prev = s_q.clk_sy[1];
        s_d.ln_s1    = {cmd_line, dat_line};
        s_d.ln_s2    = s_q.ln_s1;
        s_d.ok_sy    = {s_q.ok_sy[0], pattern_ok};

        // line history on each card clock edge, feeds the tuned path
        s_d.smp_v = 1'b0;
        if (link_edge) begin
            s_d.hist  = {s_q.hist[`SHT_TAPS-2:0], ln};
            s_d.smp_v = 1'b1;
            // fixed path takes the edge value, tuned path a delayed one
            if (s_q.choice) begin
                s_d.smp = s_q.hist[t_tap];
            end else begin
                s_d.smp = ln;
            end
        end

        // tuning control bits
        if (start_p) begin
            s_d.start  = 1'b1;
            s_d.choice = 1'b0;
        end else if (abort_p) begin
            s_d.start = 1'b0;
        end else if (t_done) begin
            s_d.start  = 1'b0;
            s_d.choice = t_pass;
        end
        // a one written to choice never sets it; a zero clears it
        if (circ_rst_p) begin
            s_d.choice = 1'b0;
        end
        if (t_done) begin
            ev[`SHT_ST_PASS] = t_pass;
            ev[`SHT_ST_FAIL] = ~t_pass;
        end

        // other control fields
        if (wr_ctrl) begin
            // enable held off when the controller cannot take async irqs
            s_d.async_en = pwdata[`SHT_CTRL_ASYNC] & ASYNC_CAP;
            s_d.bus4     = pwdata[`SHT_CTRL_BUS4];
            s_d.clk_en   = pwdata[`SHT_CTRL_CLKEN];
        end

        // card interrupt: only dat1 in 4-bit mode counts
        if (s_q.bus4 && dat1_low) begin
            // async path needs no card clock edge at all
            if (s_q.async_en || link_edge) begin
                ev[`SHT_ST_CARD] = 1'b1;
            end
        end

        // apb setup: capture answer so the access phase is a flop
        s_d.pready  = psel & ~penable;
        s_d.pslverr = psel & ~penable & ~is_mapped(paddr);
        s_d.prdata  = 32'h0000_0000;
        s_d.rd_clr  = '0;
        if (psel && !penable && !pwrite) begin
            s_d.prdata = rd_mux(paddr, s_q, t_busy, t_tap);
            if (paddr == `SHT_OFF_STATUS) begin
                s_d.rd_clr = s_q.stat;   // clear only what was shown
            end
        end

        // mask write
        if (acc && pwrite && paddr == `SHT_OFF_MASK) begin
            s_d.mask = pwdata[`SHT_ST_W-1:0];
        end

        // sticky status: a new event wins over the read clear
        if (acc && !pwrite && paddr == `SHT_OFF_STATUS) begin
            s_d.stat = (s_q.stat & ~s_q.rd_clr) | ev;
        end else begin
            s_d.stat = s_q.stat | ev;
        end
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************
    // outputs, all straight from flops
    // ************************************************
    assign pready            = s_q.pready;
    assign pslverr           = s_q.pslverr;
    assign prdata            = s_q.prdata;
    assign card_clock_enable = s_q.clk_en;
    assign cmd_sample        = s_q.smp[4];
    assign dat_sample        = s_q.smp[3:0];
    assign sample_valid      = s_q.smp_v;
    assign irq               = s_q.irq;
endmodule

// ### inc/sht_consts.svh
// constant offsets, field positions, reset values and counts for the tuning block
`ifndef SHT_CONSTS_SVH
`define SHT_CONSTS_SVH

// register byte offsets
`define SHT_OFF_CTRL     12'h000
`define SHT_OFF_STATUS   12'h004
`define SHT_OFF_MASK     12'h008
`define SHT_OFF_CAPS     12'h00c
`define SHT_OFF_STATE    12'h010

// control register fields
`define SHT_CTRL_START   0
`define SHT_CTRL_CHOICE  1
`define SHT_CTRL_ASYNC   2
`define SHT_CTRL_BUS4    3
`define SHT_CTRL_CLKEN   4

// status and mask fields
`define SHT_ST_PASS      0
`define SHT_ST_FAIL      1
`define SHT_ST_CARD      2
`define SHT_ST_W         3

// capability and state fields
`define SHT_CAP_ASYNC    0
`define SHT_STATE_BUSY   0
`define SHT_STATE_TAP    8

// tuning delay line
`define SHT_TAPS         16
`define SHT_TAP_W        4
`define SHT_TAP_LAST     4'hf
`define SHT_LINE_W       5

// reset values
`define SHT_RST_CTRL     5'h00
`define SHT_RST_STAT     3'h0
`define SHT_RST_TAP      4'h0

`endif

// ### inc/sht_pkg.sv
// types shared by the tuning block modules
package sht_pkg;
    `include "sht_consts.svh"

    // tuning engine states
    typedef enum logic [0:0] {
        SHT_IDLE = 1'b0,
        SHT_SEEK = 1'b1
    } sht_tune_st_e;

    // tuning engine state
    typedef struct packed {
        sht_tune_st_e          st;
        logic [`SHT_TAP_W-1:0] tap;
        logic [`SHT_TAP_W-1:0] tries;
        logic                  pass;
        logic                  done;
    } sht_tune_s;

    // top level state
    typedef struct packed {
        logic [1:0]                              clk_sy;
        logic                                    clk_prev;
        logic [`SHT_LINE_W-1:0]                  ln_s1;
        logic [`SHT_LINE_W-1:0]                  ln_s2;
        logic [1:0]                              ok_sy;
        logic [`SHT_TAPS-1:0][`SHT_LINE_W-1:0]   hist;
        logic                                    start;
        logic                                    choice;
        logic                                    async_en;
        logic                                    bus4;
        logic                                    clk_en;
        logic [`SHT_ST_W-1:0]                    stat;
        logic [`SHT_ST_W-1:0]                    mask;
        logic [`SHT_ST_W-1:0]                    rd_clr;
        logic                                    irq;
        logic [`SHT_LINE_W-1:0]                  smp;
        logic                                    smp_v;
        logic                                    pready;
        logic                                    pslverr;
        logic [31:0]                             prdata;
    } sht_main_s;
endpackage
